// ===== hw/timer_triggered_pulse_mode_regs.vh
// Register offsets, field positions, reset values and codes of the triggered pulse timer.
`ifndef TIMER_TRIGGERED_PULSE_MODE_REGS_VH
`define TIMER_TRIGGERED_PULSE_MODE_REGS_VH
`define CTRL_ONE_INDEX      12'h121
`define CTRL_ONE_ADDR       14'h0484
`define GEN_A_ADDR          14'h1000
`define GEN_B_ADDR          14'h1004
`define GEN_C_ADDR          14'h1008
`define START_ADDR          14'h100C
`define COUNT_ADDR          14'h1010
`define CTRL_ONE_RESET      8'h00
`define GEN_RESET           16'hFFFF
`define FLD_CHAN_A          0
`define FLD_CHAN_B          1
`define FLD_CHAN_C          2
`define FLD_CHAN_D          3
`define FLD_SRC_LO          4
`define FLD_SRC_HI          6
`define FLD_CLEAR           7
`define SRC_DIV1            3'h0
`define SRC_DIV2            3'h1
`define SRC_DIV4            3'h2
`define SRC_DIV8            3'h3
`define SRC_DIV32           3'h4
`define SRC_EXT             3'h5
`define SRC_OSC40           3'h6
`define SRC_FAST            3'h7
`define PRESCALE_W          5
`endif

// ===== hw/count_source_select.v
// Count source selection: prescaled system clock, external pin edge or oscillator ticks.
`timescale 1ns/100ps
`include "timer_triggered_pulse_mode_regs.vh"
module count_source_select (
  // Clock and reset.
  input  wire       clk_i,
  input  wire       reset_i,
  // Source code and raw sources.
  input  wire [2:0] sel_i,
  input  wire       ext_clk_i,
  input  wire       osc40_tick_i,
  input  wire       fast_tick_i,
  // One-cycle count event.
  output reg        tick_o
);
  reg  [`PRESCALE_W-1:0] pre_reg;
  reg  [2:0]             ext_sync_reg;
  reg  [1:0]             o40_sync_reg;
  reg  [1:0]             fst_sync_reg;
  reg                    o40_last_reg;
  reg                    fst_last_reg;
  reg                    tick_next;
  wire [`PRESCALE_W-1:0] pre_inc = pre_reg + 5'h01;

  always @* begin
    case (sel_i)
      `SRC_DIV1:  tick_next = 1'b1;
      `SRC_DIV2:  tick_next = (pre_inc[0] == 1'b0);
      `SRC_DIV4:  tick_next = (pre_inc[1:0] == 2'h0);
      `SRC_DIV8:  tick_next = (pre_inc[2:0] == 3'h0);
      `SRC_DIV32: tick_next = (pre_inc == 5'h00);
      `SRC_EXT:   tick_next = ext_sync_reg[1] & ~ext_sync_reg[2];
      `SRC_OSC40: tick_next = o40_sync_reg[1] & ~o40_last_reg;
      default:    tick_next = fst_sync_reg[1] & ~fst_last_reg;
    endcase
  end

  // Stage 0 of each synchroniser feeds only stage 1.
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      pre_reg      <= 5'h00;
      ext_sync_reg <= 3'h0;
      o40_sync_reg <= 2'h0;
      fst_sync_reg <= 2'h0;
      o40_last_reg <= 1'b0;
      fst_last_reg <= 1'b0;
      tick_o       <= 1'b0;
    end else begin
      pre_reg      <= pre_inc;
      ext_sync_reg <= {ext_sync_reg[1:0], ext_clk_i};
      o40_sync_reg <= {o40_sync_reg[0], osc40_tick_i};
      fst_sync_reg <= {fst_sync_reg[0], fast_tick_i};
      o40_last_reg <= o40_sync_reg[1];
      fst_last_reg <= fst_sync_reg[1];
      tick_o       <= tick_next;
    end
  end
endmodule // count_source_select

// ===== hw/triggered_pulse_mode_output_stage.v
// Channel B waveform stage: initial level on control write, set and reset on compare matches.
`timescale 1ns/100ps
`include "timer_triggered_pulse_mode_regs.vh"
module triggered_pulse_mode_output_stage (
  // Clock and reset.
  input  wire clk_i,
  input  wire reset_i,
  // Controls.
  input  wire level_sel_i,
  input  wire waveform_en_i,
  input  wire ctrl_write_i,
  input  wire match_b_i,
  input  wire match_c_i,
  // Pin.
  output reg  pin_o,
  output wire pin_oe_o
);
  assign pin_oe_o = waveform_en_i;

  // A control write wins over a match in the same cycle; match B wins over match C.
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      pin_o <= 1'b0;
    end else if (ctrl_write_i) begin
      pin_o <= level_sel_i; // RQ7
    end else if (match_b_i) begin
      pin_o <= level_sel_i; // RQ1 RQ2
    end else if (match_c_i) begin
      pin_o <= ~level_sel_i; // RQ1 RQ2
    end
  end
endmodule // triggered_pulse_mode_output_stage

// ===== hw/timer_triggered_pulse_mode_control_one.v
// Triggered pulse timer top: APB register file, counter, compare logic and channel B output.
//
// Register access over APB was left to the implementer.
`timescale 1ns/100ps
`include "timer_triggered_pulse_mode_regs.vh"
//
// Contract
// RQ1: Level select B at 0: start low, match C drives high, match B low.
// RQ2: Level select B at 1: start high, match C drives low, match B high.
// RQ3: Level select bits A and C are stored but steer no output.
// RQ4: Bits 6..4 pick source: clk/1,/2,/4,/8,/32, pin edge, 40MHz osc, fast osc.
// RQ5: Clear bit 0 free-runs; 1 clears counter on match with register A.
// RQ6: Software changes control bits only while counting is stopped.
// RQ7: Writing the control register drives the pin to its initial level.
// RQ8: Software keeps the fast oscillator above the processor clock frequency.
// RQ9: Register A sets period; B and C set change points, C the wait.
// RQ10: Counter steps once per source event while running; control resets to zero.
module timer_triggered_pulse_mode_control_one #(
  parameter CNT_W = 16
) (
  // Clock and reset.
  input  wire             clk_i,
  input  wire             reset_i,
  // APB slave.
  input  wire             psel_i,
  input  wire             penable_i,
  input  wire             pwrite_i,
  input  wire [13:0]      paddr_i,
  input  wire [31:0]      pwdata_i,
  input  wire [3:0]       pstrb_i,
  output wire             pready_o,
  output reg  [31:0]      prdata_o,
  output wire             pslverr_o,
  // Count sources.
  input  wire             ext_clk_i,
  input  wire             osc40_tick_i,
  input  wire             fast_tick_i,
  // Pin configuration and channel B pin.
  input  wire             chan_b_waveform_en_i,
  output wire             chan_b_pin_o,
  output wire             chan_b_pin_oe_o,
  // Status.
  output reg  [CNT_W-1:0] count_o
);
  reg  [7:0]       timer_triggered_pulse_mode_control_one_reg;
  reg  [CNT_W-1:0] general_reg_a_reg;
  reg  [CNT_W-1:0] general_reg_b_reg;
  reg  [CNT_W-1:0] general_reg_c_reg;
  reg              count_start_bit_reg;
  reg  [1:0]       wave_sync_reg;
  reg  [31:0]      rdata_next;
  reg              hit_next;
  wire             tick;
  wire             access = psel_i & penable_i;
  wire             wr = access & pwrite_i;
  wire             ctrl_wr;
  wire             counter_clear_select;
  wire [2:0]       count_source_sel;
  wire             chan_b_level_select;
  wire             match_a;
  wire             match_b;
  wire             match_c;
  wire [CNT_W-1:0] count_inc = count_o + {{(CNT_W-1){1'b0}}, 1'b1};
  wire [7:0]       ctrl_wdata = pwdata_i[15:8];
  // A control write takes its level from the bus data, since the register loads at that edge.
  wire             b_level_in = ctrl_wr ? ctrl_wdata[`FLD_CHAN_B] : chan_b_level_select; // RQ7

  assign counter_clear_select = timer_triggered_pulse_mode_control_one_reg[`FLD_CLEAR];
  assign count_source_sel     = timer_triggered_pulse_mode_control_one_reg[`FLD_SRC_HI:`FLD_SRC_LO]; // RQ4
  // Only bit B reaches the output; bits A, C and D are storage only.
  assign chan_b_level_select  = timer_triggered_pulse_mode_control_one_reg[`FLD_CHAN_B]; // RQ3
  assign ctrl_wr   = wr & (paddr_i == `CTRL_ONE_ADDR) & pstrb_i[1];
  assign pready_o  = 1'b1;
  assign pslverr_o = access & ~hit_next;

  // Matches count only on a count event while running, so each fires once per period.
  assign match_a = count_start_bit_reg & tick & (count_o == general_reg_a_reg); // RQ9
  assign match_b = count_start_bit_reg & tick & (count_o == general_reg_b_reg); // RQ9
  assign match_c = count_start_bit_reg & tick & (count_o == general_reg_c_reg); // RQ9

  always @* begin
    rdata_next = 32'h00000000;
    hit_next   = 1'b1;
    case (paddr_i)
      `CTRL_ONE_ADDR: rdata_next = {16'h0000, timer_triggered_pulse_mode_control_one_reg, 8'h00};
      `GEN_A_ADDR:    rdata_next[CNT_W-1:0] = general_reg_a_reg;
      `GEN_B_ADDR:    rdata_next[CNT_W-1:0] = general_reg_b_reg;
      `GEN_C_ADDR:    rdata_next[CNT_W-1:0] = general_reg_c_reg;
      `START_ADDR:    rdata_next[0] = count_start_bit_reg;
      `COUNT_ADDR:    rdata_next[CNT_W-1:0] = count_o;
      default:        hit_next = 1'b0;
    endcase
  end

  // The control register sits in byte lane 1 because its index is odd.
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      timer_triggered_pulse_mode_control_one_reg <= `CTRL_ONE_RESET; // RQ10
      general_reg_a_reg          <= `GEN_RESET;
      general_reg_b_reg          <= `GEN_RESET;
      general_reg_c_reg          <= `GEN_RESET;
      count_start_bit_reg        <= 1'b0;
      prdata_o                   <= 32'h00000000;
    end else begin
      // Read data loads in the setup phase so it stands through the zero-wait access phase.
      if (psel_i & ~penable_i & ~pwrite_i) begin
        prdata_o <= rdata_next;
      end
      if (ctrl_wr) begin
        timer_triggered_pulse_mode_control_one_reg <= ctrl_wdata;
      end
      if (wr & (paddr_i == `GEN_A_ADDR)) begin
        general_reg_a_reg <= pwdata_i[CNT_W-1:0];
      end
      if (wr & (paddr_i == `GEN_B_ADDR)) begin
        general_reg_b_reg <= pwdata_i[CNT_W-1:0];
      end
      if (wr & (paddr_i == `GEN_C_ADDR)) begin
        general_reg_c_reg <= pwdata_i[CNT_W-1:0];
      end
      if (wr & (paddr_i == `START_ADDR) & pstrb_i[0]) begin
        count_start_bit_reg <= pwdata_i[0];
      end
    end
  end

  // Software writes the counter only while stopped; a running count wins otherwise.
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      count_o <= {CNT_W{1'b0}};
    end else if (match_a & counter_clear_select) begin
      count_o <= {CNT_W{1'b0}}; // RQ5
    end else if (count_start_bit_reg & tick) begin
      count_o <= count_inc; // RQ10 RQ5
    end else if (~count_start_bit_reg & wr & (paddr_i == `COUNT_ADDR)) begin
      count_o <= pwdata_i[CNT_W-1:0];
    end
  end

  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      wave_sync_reg <= 2'h0;
    end else begin
      wave_sync_reg <= {wave_sync_reg[0], chan_b_waveform_en_i};
    end
  end

  count_source_select u_src (
    .clk_i        (clk_i),
    .reset_i      (reset_i),
    .sel_i        (count_source_sel),
    .ext_clk_i    (ext_clk_i),
    .osc40_tick_i (osc40_tick_i),
    .fast_tick_i  (fast_tick_i),
    .tick_o       (tick)
  );

  triggered_pulse_mode_output_stage u_out (
    .clk_i         (clk_i),
    .reset_i       (reset_i),
    .level_sel_i   (b_level_in),
    .waveform_en_i (wave_sync_reg[1]),
    .ctrl_write_i  (ctrl_wr),
    .match_b_i     (match_b),
    .match_c_i     (match_c),
    .pin_o         (chan_b_pin_o),
    .pin_oe_o      (chan_b_pin_oe_o)
  );
endmodule // timer_triggered_pulse_mode_control_one

// ===== testbench/triggered_pulse_mode_asserts.sv
// Port assertions of the triggered pulse timer top and their bind.
`timescale 1ns/100ps
`include "timer_triggered_pulse_mode_regs.vh"
module triggered_pulse_mode_asserts #(parameter CNT_W = 16) (
  input wire             clk_i,
  input wire             reset_i,
  input wire             psel_i,
  input wire             penable_i,
  input wire             pwrite_i,
  input wire [13:0]      paddr_i,
  input wire [31:0]      pwdata_i,
  input wire [3:0]       pstrb_i,
  input wire             pready_o,
  input wire [31:0]      prdata_o,
  input wire             pslverr_o,
  input wire             ext_clk_i,
  input wire             osc40_tick_i,
  input wire             fast_tick_i,
  input wire             chan_b_waveform_en_i,
  input wire             chan_b_pin_o,
  input wire             chan_b_pin_oe_o,
  input wire [CNT_W-1:0] count_o
);
  wire acc = psel_i & penable_i;
  wire ctl = acc && paddr_i == `CTRL_ONE_ADDR;
  wire ctlw = ctl && pwrite_i && pstrb_i[1];
  wire cntw = acc && pwrite_i && paddr_i == `COUNT_ADDR;
  wire mapped = ctl || (paddr_i[13:5] == 9'h080 && paddr_i[4:0] <= 5'h10
                && paddr_i[1:0] == 2'h0);
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  chk_init_level: assert property (ctlw |=> chan_b_pin_o == $past(pwdata_i[9]))
    else $error("pin not at initial level after control write");
  chk_oe_follow: assert property ($rose(chan_b_waveform_en_i) |-> ##[1:4] chan_b_pin_oe_o)
    else $error("pin enable did not follow waveform enable");
  chk_pin_still: assert property (count_o == $past(count_o) && count_o == $past(count_o, 2)
    && !$past(ctlw) && !$past(ctlw, 2) |-> $stable(chan_b_pin_o))
    else $error("pin moved without match or control write");
  chk_count_step: assert property ($changed(count_o) && !$past(cntw)
    |-> count_o == $past(count_o) + 1'b1 || count_o == 0)
    else $error("counter jumped");
  chk_ctrl_reads: assert property (ctl && !pwrite_i |=> prdata_o[31:16] == 0
    && prdata_o[7:0] == 0) else $error("control readback has stray bits");
  chk_rdata_hold: assert property (!(psel_i && !penable_i && !pwrite_i) |=> $stable(prdata_o))
    else $error("read data moved without a read");
  chk_err_unmapped: assert property (acc && !mapped |-> pslverr_o ##1
    ($past(pwrite_i) ? prdata_o == $past(prdata_o) : prdata_o == 0))
    else $error("unmapped not refused");
  chk_err_mapped: assert property (acc && mapped |-> !pslverr_o && pready_o)
    else $error("mapped access refused");
  cover property (ctlw ##1 chan_b_pin_o);
  cover property (acc && !mapped);
  cover property ($fell(chan_b_pin_o) && !$past(ctlw));
endmodule // triggered_pulse_mode_asserts
bind timer_triggered_pulse_mode_control_one triggered_pulse_mode_asserts #(.CNT_W(CNT_W)) chk (.clk_i(clk_i),
  .reset_i(reset_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
  .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .pready_o(pready_o),
  .prdata_o(prdata_o), .pslverr_o(pslverr_o), .ext_clk_i(ext_clk_i),
  .osc40_tick_i(osc40_tick_i), .fast_tick_i(fast_tick_i), .count_o(count_o),
  .chan_b_waveform_en_i(chan_b_waveform_en_i), .chan_b_pin_o(chan_b_pin_o),
  .chan_b_pin_oe_o(chan_b_pin_oe_o));

// ===== testbench/pin_load.sv
// Load on the channel B pin, pulled low whenever the pin is not driven.
`timescale 1ns/100ps
module pin_load (
  // Pin and its enable.
  input  wire pin_i,
  input  wire oe_i,
  // Level the load sees.
  output wire level_o
);
  assign level_o = oe_i ? pin_i : 1'b0;
endmodule // pin_load

// ===== testbench/testbench.sv
// Self-checking bench of the triggered pulse timer top.
`timescale 1ns/100ps
`include "timer_triggered_pulse_mode_regs.vh"
module testbench;
  reg         clk_i, reset_i, psel_i, penable_i, pwrite_i, er;
  reg         ext_clk_i, osc40_tick_i, fast_tick_i, chan_b_waveform_en_i;
  reg  [13:0] paddr_i;
  reg  [31:0] pwdata_i, rd;
  reg  [3:0]  pstrb_i, ph;
  wire        pready_o, pslverr_o, chan_b_pin_o, chan_b_pin_oe_o, seen;
  wire [31:0] prdata_o;
  wire [15:0] count_o;
  integer     miscompares, comparisons, i, n, t, ctrl_model;
  integer     rate [0:7];
  timer_triggered_pulse_mode_control_one dut (.clk_i(clk_i), .reset_i(reset_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .pstrb_i(pstrb_i), .pready_o(pready_o), .prdata_o(prdata_o), .pslverr_o(pslverr_o),
    .ext_clk_i(ext_clk_i), .osc40_tick_i(osc40_tick_i), .fast_tick_i(fast_tick_i),
    .chan_b_waveform_en_i(chan_b_waveform_en_i), .chan_b_pin_o(chan_b_pin_o),
    .chan_b_pin_oe_o(chan_b_pin_oe_o), .count_o(count_o));
  pin_load load (.pin_i(chan_b_pin_o), .oe_i(chan_b_pin_oe_o), .level_o(seen));
  initial begin
    clk_i = 0;
    forever #5 clk_i = ~clk_i;
  end
  // Sources: pin edge every 8 cycles, 40 MHz ticks every 4, fast ticks every 2.
  always @(posedge clk_i) begin
    ph <= ph + 4'h1;
    ext_clk_i <= ph[2];
    osc40_tick_i <= ph[1];
    fast_tick_i <= ph[0];
  end
  task check(input [31:0] s, input [31:0] e);
    begin
      comparisons = comparisons + 1;
      if (s !== e) begin
        miscompares = miscompares + 1;
        $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
      end
    end
  endtask
  task summarize;
    begin
      $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask
  task give_up(input integer lim);
    if (t >= lim) begin
      miscompares = miscompares + 1;
      summarize;
    end
  endtask
  task apb(input w, input [13:0] a, input [31:0] d);
    begin
      @(posedge clk_i);
      psel_i <= 1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge clk_i);
      penable_i <= 1;
      @(posedge clk_i);
      for (t = 0; t < 20 && pready_o !== 1'b1; t = t + 1) @(posedge clk_i);
      give_up(20);
      er = pslverr_o;
      rd = prdata_o;
      psel_i <= 0;
      penable_i <= 0;
    end
  endtask
  task wait_count(input [15:0] v);
    for (t = 0; t < 300 && count_o !== v; t = t + 1) begin
      @(posedge clk_i);
      #1;
    end
  endtask
  initial begin
    {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i, ph, chan_b_waveform_en_i} = 0;
    {ext_clk_i, osc40_tick_i, fast_tick_i, miscompares, comparisons} = 0;
    reset_i = 1;
    pstrb_i = 4'hF;
    rate[0] = 1; rate[1] = 2; rate[2] = 4; rate[3] = 8;
    rate[4] = 32; rate[5] = 8; rate[6] = 4; rate[7] = 2;
    n = $urandom(32'h5399);
    repeat (20) @(posedge clk_i);
    reset_i <= 0;
    chan_b_waveform_en_i <= 1;
    apb(0, `CTRL_ONE_ADDR, 0);
    check(rd, 0);
    for (i = 0; i < 8; i = i + 1) begin
      ctrl_model = $urandom & 8'hFF;
      apb(1, `CTRL_ONE_ADDR, ctrl_model << 8);
      apb(0, `CTRL_ONE_ADDR, 0);
      check(rd, ctrl_model << 8);
      check(seen, ctrl_model[1]);
      ctrl_model = ctrl_model ^ 5;
      apb(1, `CTRL_ONE_ADDR, ctrl_model << 8);
      apb(0, `CTRL_ONE_ADDR, 0);
      check(rd, ctrl_model << 8);
      check(seen, ctrl_model[1]);
    end
    pstrb_i <= 4'hD;
    apb(1, `CTRL_ONE_ADDR, 32'h0000FF00);
    pstrb_i <= 4'hF;
    apb(0, `CTRL_ONE_ADDR, 0);
    check(rd, ctrl_model << 8);
    chan_b_waveform_en_i <= 0;
    repeat (3) @(posedge clk_i);
    check({chan_b_pin_oe_o, seen}, 0);
    chan_b_waveform_en_i <= 1;
    repeat (3) @(posedge clk_i);
    check({chan_b_pin_oe_o, seen}, {1'b1, ctrl_model[1]});
    for (i = 0; i < 8; i = i + 1) begin
      apb(1, `CTRL_ONE_ADDR, i << 12);
      apb(1, `COUNT_ADDR, 0);
      apb(1, `START_ADDR, 1);
      repeat (160) @(posedge clk_i);
      apb(1, `START_ADDR, 0);
      apb(0, `COUNT_ADDR, 0);
      n = 161 / rate[i];
      check(rd[15:0] + 3 - n <= 6, 1);
    end
    apb(1, `GEN_A_ADDR, 40);
    apb(1, `GEN_B_ADDR, 30);
    apb(1, `GEN_C_ADDR, 10);
    for (i = 0; i < 2; i = i + 1) begin
      apb(1, `START_ADDR, 0);
      apb(1, `COUNT_ADDR, 0);
      apb(1, `CTRL_ONE_ADDR, (8'h80 | i << 1) << 8);
      @(negedge clk_i);
      check(seen, i);
      apb(1, `START_ADDR, 1);
      wait_count(20);
      give_up(300);
      check(seen, !i);
      wait_count(35);
      give_up(300);
      check(seen, i);
      wait_count(5);
      give_up(300);
      check(seen, i);
    end
    apb(1, `START_ADDR, 0);
    apb(1, 14'h0200, 32'hFFFFFFFF);
    check(er, 1);
    apb(0, 14'h0200, 0);
    check(er, 1);
    check(rd, 0);
    summarize;
  end
endmodule // testbench
